/* File: pkg/bst_pkg.sv */
// Purpose: Shared constants and types for the boundary-scan test port.
// Assumes: Four-bit instruction register and an eight-pin boundary chain.
// Notes:   Identification field values are arbitrary neutral values.
package bst_pkg;

    // ----------------------------------------------------------------
    // Controller states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET   = 4'hf,
        ST_IDLE    = 4'hc,
        ST_SEL_DR  = 4'h7,
        ST_CAP_DR  = 4'h6,
        ST_SH_DR   = 4'h2,
        ST_EX1_DR  = 4'h1,
        ST_PA_DR   = 4'h3,
        ST_EX2_DR  = 4'h0,
        ST_UPD_DR  = 4'h5,
        ST_SEL_IR  = 4'h4,
        ST_CAP_IR  = 4'he,
        ST_SH_IR   = 4'ha,
        ST_EX1_IR  = 4'h9,
        ST_PA_IR   = 4'hb,
        ST_EX2_IR  = 4'h8,
        ST_UPD_IR  = 4'hd
    } bst_state_e;

    // ----------------------------------------------------------------
    // Instructions and data register selection
    // ----------------------------------------------------------------
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INS_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] INS_HIGHZ = 4'h3;
    localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;

    typedef enum logic [1:0] {
        SEL_BYP = 2'h0,
        SEL_ID  = 2'h1,
        SEL_BSR = 2'h2
    } bst_sel_e;

    // ----------------------------------------------------------------
    // Identification register fields (values arbitrary)
    // ----------------------------------------------------------------
    localparam int ID_W = 32;
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'h0a5c;
    localparam logic [10:0] ID_MAKER = 11'h02a;
    localparam logic ID_LSB = 1'b1;

    // ----------------------------------------------------------------
    // Boundary chain and reset values
    // ----------------------------------------------------------------
    localparam int NPIN = 8;
    localparam logic [NPIN-1:0] BSR_RST = 8'h00;
    localparam logic BYP_CAPTURE = 1'b0;

endpackage

/* File: src/bst_tap.sv */
// Purpose: Test access port, controller, instruction and data registers.
// Assumes: tck is the tester's clock; core_clk runs the pad logic.
// Notes:   Update values are static while the pads read them.
//
// What this block does
// - Four pins: clock, data in, data out, mode.
// - Sixteen states held in a four-bit register.
// - Mode level at rising clock picks transitions.
// - Controller derives register capture, shift, update strobes.
// - Power-up reset enters Test-Logic-Reset with no activity.
// - Mode high five edges reaches Test-Logic-Reset.
// - Decode EXTEST, SAMPLE/PRELOAD, BYPASS plus optional ones.
// - Bypass, identification, boundary registers chosen by instruction.
// - Bypass selected whenever no other register used.
// - Identification is 32 bits in four fields.
// - One boundary cell per pin: capture, drive.
`timescale 1ns/100ps
module bst_tap (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Test access port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Functional side of the pads
    input wire logic [bst_pkg::NPIN-1:0] func_out,
    input wire logic [bst_pkg::NPIN-1:0] func_oe,
    // Pads
    input wire logic [bst_pkg::NPIN-1:0] pad_in,
    output logic [bst_pkg::NPIN-1:0] pad_out,
    output logic [bst_pkg::NPIN-1:0] pad_oe
);
    import bst_pkg::*;

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    function automatic bst_sel_e dr_sel(input logic [IR_W-1:0] ins);
        case (ins)
            INS_EXTEST: dr_sel = SEL_BSR;
            INS_SAMPLE: dr_sel = SEL_BSR;
            INS_IDCODE: dr_sel = SEL_ID;
            default: dr_sel = SEL_BYP;
        endcase
    endfunction

    bst_state_e state_r;
    bst_state_e state_nxt;
    logic [IR_W-1:0] ir_sh_r;
    logic [IR_W-1:0] ir_r;
    logic byp_r;
    logic [ID_W-1:0] id_sh_r;
    logic [NPIN-1:0] bsr_sh_r;
    logic [NPIN-1:0] bsr_upd_r;
    logic [NPIN-1:0] pin_m_r;
    logic [NPIN-1:0] pin_s_r;
    logic ext_r;
    logic hiz_r;
    logic upd_tg_r;
    logic tdo_nxt;
    bst_sel_e sel;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;

    // ----------------------------------------------------------------
    // Controller
    // ----------------------------------------------------------------
    // The power-up reset puts the controller in Test-Logic-Reset.
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Every state moves towards reset on a high mode level, so five
    // high edges reach reset from the farthest state.
    always_comb begin
        case (state_r)
            ST_RESET: state_nxt = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: state_nxt = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_nxt = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: state_nxt = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
            default: state_nxt = ST_RESET;
        endcase
    end

    assign sel = dr_sel(ir_r);
    assign cap_dr = (state_r == ST_CAP_DR);
    assign sh_dr = (state_r == ST_SH_DR);
    assign upd_dr = (state_r == ST_UPD_DR);

    // ----------------------------------------------------------------
    // Instruction register
    // ----------------------------------------------------------------
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            ir_sh_r <= IR_RESET;
        end else if (state_r == ST_CAP_IR) begin
            ir_sh_r <= IR_CAPTURE;
        end else if (state_r == ST_SH_IR) begin
            ir_sh_r <= {tdi, ir_sh_r[IR_W-1:1]};
        end
    end

    // The active instruction changes only at a rising test clock edge in Update-IR or Test-Logic-Reset, so the
    // selected data register never moves during a shift.
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            ir_r <= IR_RESET;
        end else if (state_r == ST_RESET) begin
            ir_r <= IR_RESET;
        end else if (state_r == ST_UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    // Mode levels handed to the pad logic. They move at the same edge as
    // the instruction, so no further test clock edge is needed while the
    // tester holds its clock still between frames.
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            ext_r <= 1'b0;
            hiz_r <= 1'b0;
        end else if (state_r == ST_RESET) begin
            ext_r <= 1'b0;
            hiz_r <= 1'b0;
        end else if (state_r == ST_UPD_IR) begin
            ext_r <= (ir_sh_r == INS_EXTEST);
            hiz_r <= (ir_sh_r == INS_HIGHZ);
        end
    end

    // ----------------------------------------------------------------
    // Data registers
    // ----------------------------------------------------------------
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            byp_r <= BYP_CAPTURE;
        end else if (cap_dr) begin
            byp_r <= BYP_CAPTURE;
        end else if (sh_dr) begin
            byp_r <= tdi;
        end
    end

    // The identification word is loaded whole at every capture.
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            id_sh_r <= '0;
        end else if (cap_dr) begin
            id_sh_r <= {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
        end else if (sh_dr && sel == SEL_ID) begin
            id_sh_r <= {tdi, id_sh_r[ID_W-1:1]};
        end
    end

    // Pads are asynchronous to the test clock.
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            pin_m_r <= '0;
            pin_s_r <= '0;
        end else begin
            pin_m_r <= pad_in;
            pin_s_r <= pin_m_r;
        end
    end

    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            bsr_sh_r <= BSR_RST;
        end else if (cap_dr && sel == SEL_BSR) begin
            bsr_sh_r <= pin_s_r;
        end else if (sh_dr && sel == SEL_BSR) begin
            bsr_sh_r <= {tdi, bsr_sh_r[NPIN-1:1]};
        end
    end

    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            bsr_upd_r <= BSR_RST;
        end else if (upd_dr && sel == SEL_BSR) begin
            bsr_upd_r <= bsr_sh_r;
        end
    end

    // Flips at every boundary register update so the core side knows that a new word stands.
    // The word itself then holds still until the next update.
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            upd_tg_r <= 1'b0;
        end else if (upd_dr && sel == SEL_BSR) begin
            upd_tg_r <= !upd_tg_r;
        end
    end

    // ----------------------------------------------------------------
    // Serial output
    // ----------------------------------------------------------------
    always_comb begin
        if (state_r == ST_SH_IR) begin
            tdo_nxt = ir_sh_r[0];
        end else begin
            case (sel)
                SEL_ID: tdo_nxt = id_sh_r[0];
                SEL_BSR: tdo_nxt = bsr_sh_r[0];
                default: tdo_nxt = byp_r;
            endcase
        end
    end

    // Launching on the falling edge gives the next device in the chain
    // half a test clock period of setup.
    always_ff @(negedge tck or negedge resetn) begin
        if (!resetn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo <= tdo_nxt;
            tdo_oe <= sh_dr || (state_r == ST_SH_IR);
        end
    end

    // ----------------------------------------------------------------
    // Pad logic in the core domain
    // ----------------------------------------------------------------
    logic ext_m_r;
    logic ext_s_r;
    logic hiz_m_r;
    logic hiz_s_r;
    // The update word crosses whole, qualified by its synchronised toggle,
    // so no mixture of old and new bits ever reaches the pads.
    logic tg_m_r;
    logic tg_s_r;
    logic tg_d_r;
    logic [NPIN-1:0] upd_c_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ext_m_r <= 1'b0;
            ext_s_r <= 1'b0;
            hiz_m_r <= 1'b0;
            hiz_s_r <= 1'b0;
            tg_m_r <= 1'b0;
            tg_s_r <= 1'b0;
            tg_d_r <= 1'b0;
        end else begin
            ext_m_r <= ext_r;
            ext_s_r <= ext_m_r;
            hiz_m_r <= hiz_r;
            hiz_s_r <= hiz_m_r;
            tg_m_r <= upd_tg_r;
            tg_s_r <= tg_m_r;
            tg_d_r <= tg_s_r;
        end
    end

    // The word has stood still since its toggle flipped, so it is taken
    // once that toggle has passed both flip-flops.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            upd_c_r <= BSR_RST;
        end else if (tg_s_r != tg_d_r) begin
            upd_c_r <= bsr_upd_r;
        end
    end

    // Each pin drives the boundary word under the external test, else the
    // core's own value; the high-impedance test turns every driver off.
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_cell
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    pad_out[g] <= 1'b0;
                    pad_oe[g] <= 1'b0;
                end else begin
                    pad_out[g] <= ext_s_r ? upd_c_r[g] : func_out[g];
                    pad_oe[g] <= !hiz_s_r && (ext_s_r || func_oe[g]);
                end
            end
        end
    endgenerate

endmodule

/* File: bench/bst_tap_properties.sv */
// Purpose: Port-level checks of the test port.
// Assumes: Bound to every instance of bst_tap.
// Notes:   The pad-following check applies until the first mode-low test clock edge.
`timescale 1ns/100ps
module bst_tap_chk
    import bst_pkg::*;
(
    // Clocks and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Test access port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    // Pads
    input wire logic [NPIN-1:0] func_out,
    input wire logic [NPIN-1:0] func_oe,
    input wire logic [NPIN-1:0] pad_in,
    input wire logic [NPIN-1:0] pad_out,
    input wire logic [NPIN-1:0] pad_oe
);
    // ----
    // Checks
    // ----
    logic low_seen_r;
    always_ff @(posedge tck or negedge resetn) begin
        if (!resetn) begin
            low_seen_r <= 1'b0;
        end else if (!tms) begin
            low_seen_r <= 1'b1;
        end
    end
    exits_shift_a: assert property (@(posedge tck) disable iff (!resetn)
        $past(tms) |-> !tdo_oe) else $error("tdo on after mode high");
    shift_stays_a: assert property (@(posedge tck) disable iff (!resetn)
        tdo_oe && !tms |=> tdo_oe) else $error("shift left on mode low");
    exit_cause_a: assert property (@(posedge tck) disable iff (!resetn)
        $fell(tdo_oe) |-> $past(tms)) else $error("tdo off without cause");
    idcode_first_a: assert property (@(posedge tck) disable iff (!resetn)
        tms[*5] ##1 !tms ##1 tms ##1 !tms ##1 !tms |=> tdo_oe && tdo == ID_LSB)
        else $error("identification bit wrong");
    ir_capture_a: assert property (@(posedge tck) disable iff (!resetn)
        tms[*5] ##1 !tms ##1 tms[*2] ##1 (!tms)[*2] |=> tdo_oe && tdo == IR_CAPTURE[0])
        else $error("instruction capture bit wrong");
    tdo_edge_a: assert property (@(posedge core_clk) disable iff (!resetn)
        tck && $past(tck) |-> $stable(tdo) && $stable(tdo_oe))
        else $error("tdo moved while clock high");
    reset_quiet_a: assert property (@(posedge core_clk)
        !resetn |-> !tdo_oe && !tdo && pad_oe == '0 && pad_out == '0)
        else $error("outputs active in reset");
    pads_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $past(resetn, 2) && !low_seen_r |->
        pad_out == $past(func_out) && pad_oe == $past(func_oe))
        else $error("pads not following core");
endmodule
bind bst_tap bst_tap_chk u_chk (.core_clk(core_clk), .resetn(resetn),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .func_out(func_out), .func_oe(func_oe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe));

/* File: bench/bst_tester.sv */
// Purpose: Behavioural tester driving the test port.
// Assumes: Mode and data change while the test clock is low.
// Notes:   The test clock stands low between frames.
`timescale 1ns/100ps
module bst_tester (
    // Test access port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // ----
    // Frames
    // ----
    logic tdo_s;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        tdo_s = 1'b0;
    end
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #24 tck = 1'b1;
        tdo_s = tdo_oe ? tdo : ~tdo_s;
        #24 tck = 1'b0;
    endtask
    task automatic rst();
        repeat (5) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic scan(input logic [31:0] d, input int n,
                        output logic [31:0] q);
        q = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i]);
            q[i] = tdo_s;
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic ir(input logic [3:0] v, output logic [31:0] q);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        scan({28'h0, v}, 4, q);
    endtask
    task automatic dr(input logic [31:0] d, input int n,
                      output logic [31:0] q);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        scan(d, n, q);
    endtask
endmodule

/* File: bench/boundary_scan_tap_tb_top.sv */
// Purpose: Self-checking bench of the test port.
// Assumes: The tester model drives the link side.
// Notes:   Core inputs are random from a fixed seed.
`timescale 1ns/100ps
module boundary_scan_tap_tb_top;
    import bst_pkg::*;
    `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
        mismatches++; $display("wrong value at %0t: %h %h", $time, a, b); \
        end end
    // ----
    // Bench
    // ----
    logic core_clk, resetn, tck, tms, tdi, tdo, tdo_oe, rnd_on;
    logic [NPIN-1:0] func_out, func_oe, pad_in, pad_out, pad_oe;
    logic [31:0] seed, rs, q, d;
    logic [3:0] ops [2] = '{INS_BYPASS, 4'h7};
    int mismatches, tests_run;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] idv();
        return {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
    endfunction
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (rnd_on) begin
            seed = nx(seed);
            func_out = seed[7:0];
            func_oe = seed[15:8];
        end
    end
    bst_tap uut (.core_clk(core_clk), .resetn(resetn), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .func_out(func_out), .func_oe(func_oe), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe));
    bst_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));
    task automatic results();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic pads(input logic [7:0] o, input logic [7:0] e);
        int n;
        n = 0;
        while ((pad_out !== o || pad_oe !== e) && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(pad_out, o)
        `CHK(pad_oe, e)
        if (n == 40 && (pad_out !== o || pad_oe !== e)) results();
    endtask
    initial begin
        resetn = 1'b1;
        rnd_on = 1'b1;
        seed = 32'h2d1eacc8;
        rs = seed;
        func_out = '0;
        func_oe = '0;
        pad_in = '0;
        mismatches = 0;
        tests_run = 0;
        #1 resetn = 1'b0;
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        #5;
        tst.rst();
        rnd_on = 1'b0;
        tst.dr(32'h0, 32, q);
        `CHK(q, idv())
        `CHK(tdo_oe, 1'b0)
        foreach (ops[i]) begin
            tst.rst();
            tst.ir(ops[i], q);
            `CHK(q[3:0], IR_CAPTURE)
            rs = nx(rs);
            tst.dr(rs, 9, q);
            `CHK(q[8:0], {rs[7:0], BYP_CAPTURE})
        end
        rs = nx(rs);
        d = rs;
        pad_in = d[7:0];
        tst.ir(INS_SAMPLE, q);
        tst.dr({24'h0, d[15:8]}, 8, q);
        `CHK(q[7:0], d[7:0])
        tst.ir(INS_EXTEST, q);
        pads(d[15:8], 8'hff);
        rs = nx(rs);
        tst.dr(rs, 8, q);
        `CHK(q[7:0], d[7:0])
        pads(rs[7:0], 8'hff);
        tst.ir(INS_HIGHZ, q);
        pads(func_out, 8'h00);
        tst.rst();
        pads(func_out, func_oe);
        @(negedge core_clk);
        resetn = 1'b0;
        @(negedge core_clk);
        `CHK(pad_oe, 8'h00)
        results();
    end
endmodule
